//--- pkg/crc_scan_pkg.sv
// Shared constants, carrier types and the checksum step of the flash checksum scanner.
package crc_scan_pkg;

    // Register indices; the bus byte address is four times the index.
    localparam logic [1:0] IDX_SCAN_CONTROL = 2'h0;
    localparam logic [1:0] IDX_SCAN_SOURCE  = 2'h1;
    localparam logic [1:0] IDX_SCAN_STATE   = 2'h2;
    localparam int         BUS_ADDR_W       = 4;
    localparam int         IDX_LSB          = 2;

    // Field positions inside the three registers.
    localparam int CTL_ENABLE_BIT = 0;
    localparam int CTL_FAILURE_INTERRUPT_ENABLE_BIT  = 1;
    localparam int CTL_RESET_BIT  = 7;
    localparam int SRC_LSB        = 0;
    localparam int MODE_LSB       = 4;
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_OK_BIT    = 1;

    // Values after reset.
    localparam logic [7:0] SCAN_CONTROL_RESET = 8'h00;
    localparam logic [7:0] SCAN_SOURCE_RESET  = 8'h00;
    localparam logic [7:0] SCAN_STATE_RESET   = 8'h02;

    // Section select and access mode encodings.
    localparam logic [1:0] SRC_FULL_FLASH     = 2'h0;
    localparam logic [1:0] SRC_BOOT_PLUS_APP  = 2'h1;
    localparam logic [1:0] SRC_BOOT_ONLY      = 2'h2;
    localparam logic [1:0] MODE_PRIORITY      = 2'h0;
    localparam logic [1:0] MODE_STARTUP       = 2'h1;

    // Cycle counts at the core clock.
    localparam int         START_DELAY_CYCLES = 3;
    localparam logic [1:0] START_DELAY_LAST   = 2'(START_DELAY_CYCLES - 1);
    localparam int         FETCH_PERIOD       = 3;
    localparam logic [1:0] FETCH_DIV_LAST     = 2'(FETCH_PERIOD - 1);

    // Flash geometry in 16-bit words; a fuse unit is 256 bytes, 128 words.
    localparam int                    FLASH_WORD_AW   = 15;
    localparam logic [FLASH_WORD_AW-1:0] FLASH_LAST_WORD = 15'h7fff;
    localparam int                    FUSE_WORD_SHIFT = 7;

    // Checksum polynomial x^16+x^12+x^5+1 and its start value.
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hffff;

    // Avalon-MM request from the master.
    typedef struct packed {
        logic                  read;
        logic                  write;
        logic [BUS_ADDR_W-1:0] address;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } avm_req_t;

    // Word fetch toward the flash array.
    typedef struct packed {
        logic                     rd;
        logic [FLASH_WORD_AW-1:0] addr;
    } flash_req_t;

    // One byte through the checksum shifter, most significant bit first.
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--)
        begin
            if (c[15] ^ data[i])
                c = {c[14:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[14:0], 1'b0};
        end
        return c;
    endfunction

endpackage

//--- hdl/flash_crc_engine.sv
// Checksum register that folds in one flash word, low byte first, per valid cycle.
`timescale 1ns/1ps
module flash_crc_engine
    import crc_scan_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Word stream.
    input  wire logic        clear,
    input  wire logic        word_valid,
    input  wire logic [15:0] word,
    // Running checksum.
    output logic [15:0]      crc
);
    logic [15:0] crc_reg;

    // Byte zero sits in the low half of each word, so it is shifted in first.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            crc_reg <= CRC_INIT;
        else if (clear)
            crc_reg <= CRC_INIT;
        else if (word_valid)
            crc_reg <= crc16_byte(crc16_byte(crc_reg, word[7:0]), word[15:8]);
    end

    assign crc = crc_reg;
endmodule

//--- hdl/flash_crc_fetch.sv
// Paced word fetch sequencer that walks a flash section from word zero upward.
`timescale 1ns/1ps
module flash_crc_fetch
    import crc_scan_pkg::*;
(
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Control from the scanner.
    input  wire logic                     start,
    input  wire logic                     run,
    input  wire logic [FLASH_WORD_AW-1:0] last_word,
    // Flash side.
    output crc_scan_pkg::flash_req_t      flash_req,
    // Word stream toward the checksum.
    output logic                          word_valid,
    output logic                          word_last
);
    logic [1:0]               div_reg;
    logic [FLASH_WORD_AW-1:0] addr_reg;
    logic                     issued_all_reg;
    logic                     rd_reg;
    logic [FLASH_WORD_AW-1:0] rd_addr_reg;
    logic                     rd_last_reg;
    logic                     valid_reg;
    logic                     last_reg;
    logic                     issue;

    // Divider gives one fetch slot every third core cycle.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_reg <= 2'h0;
        else if (start || !run)
            div_reg <= 2'h0;
        else if (div_reg == FETCH_DIV_LAST)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    end

    assign issue = run && !start && (div_reg == 2'h0) && !issued_all_reg;

    // Address walk; stops issuing once the last word of the section went out.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_reg       <= '0;
            issued_all_reg <= 1'b0;
        end
        else if (start)
        begin
            addr_reg       <= '0;
            issued_all_reg <= 1'b0;
        end
        else if (issue)
        begin
            addr_reg       <= addr_reg + 1'b1;
            issued_all_reg <= (addr_reg == last_word);
        end
    end

    // Registered request, then the data cycle one edge later.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_reg      <= 1'b0;
            rd_addr_reg <= '0;
            rd_last_reg <= 1'b0;
            valid_reg   <= 1'b0;
            last_reg    <= 1'b0;
        end
        else
        begin
            rd_reg      <= issue;
            rd_addr_reg <= issue ? addr_reg : rd_addr_reg;
            rd_last_reg <= issue && (addr_reg == last_word);
            valid_reg   <= rd_reg && run;
            last_reg    <= rd_reg && run && rd_last_reg;
        end
    end

    assign flash_req.rd   = rd_reg;
    assign flash_req.addr = rd_addr_reg;
    assign word_valid     = valid_reg;
    assign word_last      = last_reg;
endmodule

//--- hdl/flash_checksum_scanner.sv
// Flash checksum scanner: register file, scan sequencing, pass flag and failure interrupt.
//
// Operation
// - Debugger clearing pass flag raises interrupt if enabled.
// - After interrupt, all register writes are ignored.
// - Debugger writing pass flag one reads one.
// - Debugger control writes behave like processor writes.
// - Self-reset strobe clears registers next cycle.
// - Strobe accepted when interrupt off, else only idle.
// - Interrupt enable set when idle, sticky until reset.
// - Writing enable one starts check; zero ignored.
// - Start-up scan leaves enable reading one.
// - Source register locked while busy or after interrupt.
// - Priority access mode halts processor until done.
// - Section select picks full, boot+app, or boot.
// - Start-up scan reports the section it checked.
// - Status resets to pass flag set.
// - Pass flag one means checksum matched.
// - Busy reads one during a check.
// - CCITT polynomial, start all ones, MSB first.
// - Check begins three cycles after enable write.
// - One flash word fetched every third cycle.
// - Mismatch clears pass flag; interrupt held until reset.
`timescale 1ns/1ps
module flash_checksum_scanner
    import crc_scan_pkg::*;
(
    // Clock and reset.
    input  wire logic                  CORE_CLK,
    input  wire logic                  RST_N,
    // Avalon-MM register slave.
    input  crc_scan_pkg::avm_req_t     AVS_REQ,
    output logic [31:0]                AVS_READDATA,
    output logic                       AVS_WAITREQUEST,
    // Start-up configuration and section ends.
    input  wire logic                  STARTUP_SCAN_EN,
    input  wire logic [1:0]            STARTUP_SRC,
    input  wire logic [7:0]            FUSE_BOOTEND,
    input  wire logic [7:0]            FUSE_APPEND,
    // Flash array.
    output crc_scan_pkg::flash_req_t   FLASH_REQ,
    input  wire logic [15:0]           FLASH_RDATA,
    // Processor side.
    output logic                       CPU_STALL,
    output logic                       CPU_RUN_OK,
    output logic                       NMI_REQ
);
    import crc_scan_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_DELAY = 2'b01,
        ST_SCAN  = 2'b11,
        ST_CHECK = 2'b10
    } scan_state_t;

    scan_state_t              state_reg;
    scan_state_t              state_next;
    logic                     ack_reg;
    logic [31:0]              readdata_reg;
    logic                     enable_reg;
    logic                     failure_interrupt_enable_reg;
    logic [1:0]               mode_reg;
    logic [1:0]               src_reg;
    logic                     busy_reg;
    logic                     ok_reg;
    logic                     nmi_reg;
    logic                     self_reset_reg;
    logic [1:0]               delay_reg;
    logic                     boot_arm_reg;
    logic                     boot_phase_reg;
    logic                     run_ok_reg;
    logic                     stall_reg;
    logic                     bus_take;
    logic                     wr_take;
    logic [1:0]               wr_idx;
    logic [7:0]               wdata;
    logic                     wr_ctrl;
    logic                     wr_src;
    logic                     wr_stat;
    logic                     strobe_ok;
    logic                     start_req;
    logic                     dbg_start;
    logic                     dbg_stop;
    logic                     boot_go;
    logic                     abort;
    logic                     scan_start;
    logic                     check_pass;
    logic                     word_valid;
    logic                     word_last;
    logic [15:0]              crc;
    logic [FLASH_WORD_AW-1:0] last_word;

    // Last word of a section given the select code; reserved code scans everything.
    function automatic logic [FLASH_WORD_AW-1:0] section_end(input logic [1:0] sel);
        logic [FLASH_WORD_AW-1:0] e;
        case (sel)
            SRC_BOOT_PLUS_APP: e = FLASH_WORD_AW'({FUSE_APPEND, 7'h00}) - 1'b1;
            SRC_BOOT_ONLY:     e = FLASH_WORD_AW'({FUSE_BOOTEND, 7'h00}) - 1'b1;
            default:           e = FLASH_LAST_WORD;
        endcase
        return e;
    endfunction

    // Read-back image of one register; unmapped indices read as zero.
    function automatic logic [7:0] reg_image(input logic [1:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            IDX_SCAN_CONTROL:
            begin
                v[CTL_ENABLE_BIT] = enable_reg;
                v[CTL_FAILURE_INTERRUPT_ENABLE_BIT]  = failure_interrupt_enable_reg;
            end
            IDX_SCAN_SOURCE:
            begin
                v[MODE_LSB +: 2] = mode_reg;
                v[SRC_LSB +: 2]  = src_reg;
            end
            IDX_SCAN_STATE:
            begin
                v[STAT_BUSY_BIT] = busy_reg;
                v[STAT_OK_BIT]   = ok_reg;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // Every access waits exactly one cycle, so decode and read data settle in a flop.
    assign AVS_WAITREQUEST = (AVS_REQ.read || AVS_REQ.write) && !ack_reg;
    assign bus_take        = (AVS_REQ.read || AVS_REQ.write) && ack_reg;

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ack_reg <= 1'b0;
        else
            ack_reg <= (AVS_REQ.read || AVS_REQ.write) && !ack_reg;
    end

    // Read data is captured in the waiting cycle and held until the next read.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            readdata_reg <= 32'h0000_0000;
        else if (AVS_REQ.read && !ack_reg)
            readdata_reg <= {24'h00_0000, reg_image(AVS_REQ.address[IDX_LSB +: 2])};
    end

    assign AVS_READDATA = readdata_reg;

    // Write decode; the one bus carries processor and debugger writes alike.
    assign wr_take   = bus_take && AVS_REQ.write && AVS_REQ.byteenable[0] && !nmi_reg;
    assign wr_idx    = AVS_REQ.address[IDX_LSB +: 2];
    assign wdata     = AVS_REQ.writedata[7:0];
    assign wr_ctrl   = wr_take && (wr_idx == IDX_SCAN_CONTROL);
    assign wr_src    = wr_take && (wr_idx == IDX_SCAN_SOURCE) && !busy_reg;
    assign wr_stat   = wr_take && (wr_idx == IDX_SCAN_STATE);

    // The strobe may abort a running check only while failures cannot interrupt.
    assign strobe_ok = wr_ctrl && wdata[CTL_RESET_BIT] && (!failure_interrupt_enable_reg || !busy_reg);
    assign start_req = wr_ctrl && wdata[CTL_ENABLE_BIT] && !strobe_ok && !busy_reg;
    assign dbg_start = wr_stat && wdata[STAT_BUSY_BIT] && !busy_reg;
    assign dbg_stop  = wr_stat && !wdata[STAT_BUSY_BIT] && busy_reg;
    assign boot_go   = boot_arm_reg && STARTUP_SCAN_EN;
    assign abort     = self_reset_reg || dbg_stop;
    assign last_word = section_end(src_reg);

    // The full checksum, stored value included, folds to zero on a match.
    assign check_pass = (crc == 16'h0000);

    // Scan sequencer.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
            begin
                if (boot_go || dbg_start)
                    state_next = ST_SCAN;
                else if (start_req)
                    state_next = ST_DELAY;
            end
            ST_DELAY:
            begin
                if (delay_reg == START_DELAY_LAST)
                    state_next = ST_SCAN;
            end
            ST_SCAN:
            begin
                if (word_valid && word_last)
                    state_next = ST_CHECK;
            end
            ST_CHECK:
                state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        if (abort)
            state_next = ST_IDLE;
    end

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    assign scan_start = (state_next == ST_SCAN) && (state_reg != ST_SCAN);

    // Start delay counter; the processor keeps running through these cycles.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            delay_reg <= 2'h0;
        else if (state_reg == ST_DELAY)
            delay_reg <= delay_reg + 2'h1;
        else
            delay_reg <= 2'h0;
    end

    // Busy follows the sequencer so it reads one from the start write onward.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            busy_reg <= SCAN_STATE_RESET[STAT_BUSY_BIT];
        else
            busy_reg <= (state_next != ST_IDLE);
    end

    // Strobe is remembered one cycle and never read back as one.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            self_reset_reg <= 1'b0;
        else
            self_reset_reg <= strobe_ok;
    end

    // Enable bit: set by a start or the start-up scan, cleared only by the strobe.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            enable_reg <= SCAN_CONTROL_RESET[CTL_ENABLE_BIT];
        else if (self_reset_reg)
            enable_reg <= 1'b0;
        else if (start_req || boot_go)
            enable_reg <= 1'b1;
    end

    // Interrupt enable survives the strobe; only system reset clears it.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            failure_interrupt_enable_reg <= SCAN_CONTROL_RESET[CTL_FAILURE_INTERRUPT_ENABLE_BIT];
        else if (wr_ctrl && wdata[CTL_FAILURE_INTERRUPT_ENABLE_BIT] && !busy_reg)
            failure_interrupt_enable_reg <= 1'b1;
    end

    // Source and access mode; the start-up scan loads what it is about to check.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            mode_reg <= SCAN_SOURCE_RESET[MODE_LSB +: 2];
            src_reg  <= SCAN_SOURCE_RESET[SRC_LSB +: 2];
        end
        else if (self_reset_reg)
        begin
            mode_reg <= 2'h0;
            src_reg  <= 2'h0;
        end
        else if (boot_go)
        begin
            mode_reg <= MODE_STARTUP;
            src_reg  <= STARTUP_SRC;
        end
        else if (wr_src)
        begin
            mode_reg <= wdata[MODE_LSB +: 2];
            src_reg  <= wdata[SRC_LSB +: 2];
        end
    end

    // Pass flag: the hardware verdict outranks a debugger write in the same cycle.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            ok_reg <= SCAN_STATE_RESET[STAT_OK_BIT];
        else if (self_reset_reg)
            ok_reg <= 1'b0;
        else if (state_reg == ST_CHECK)
            ok_reg <= check_pass;
        else if (wr_stat)
            ok_reg <= wdata[STAT_OK_BIT];
    end

    // Failure interrupt is sticky; nothing but system reset lowers it.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            nmi_reg <= 1'b0;
        else if (failure_interrupt_enable_reg && (state_reg == ST_CHECK) && !check_pass)
            nmi_reg <= 1'b1;
        else if (failure_interrupt_enable_reg && wr_stat && !wdata[STAT_OK_BIT] && (state_reg != ST_CHECK))
            nmi_reg <= 1'b1;
    end

    // Start-up scan is armed for the first edge after reset release only.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            boot_arm_reg   <= 1'b1;
            boot_phase_reg <= 1'b0;
            run_ok_reg     <= 1'b0;
        end
        else
        begin
            boot_arm_reg <= 1'b0;
            if (boot_go)
                boot_phase_reg <= 1'b1;
            else if (boot_phase_reg && (state_reg == ST_CHECK) && check_pass)
                boot_phase_reg <= 1'b0;
            // A failed start-up check keeps the processor out of normal execution.
            if (boot_arm_reg && !STARTUP_SCAN_EN)
                run_ok_reg <= 1'b1;
            else if (boot_phase_reg && (state_reg == ST_CHECK) && check_pass)
                run_ok_reg <= 1'b1;
        end
    end

    // Priority access holds the processor for the whole active scan.
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            stall_reg <= 1'b0;
        else
            stall_reg <= (state_next == ST_SCAN) || (state_next == ST_CHECK);
    end

    assign CPU_STALL  = stall_reg;
    assign CPU_RUN_OK = run_ok_reg;
    assign NMI_REQ    = nmi_reg;

    // Word fetcher paced by the core clock divider; an abort stops it in the same cycle,
    // so no fetch goes out after the processor has been let go.
    flash_crc_fetch flash_crc_fetch_inst (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .start      (scan_start),
        .run        ((state_reg == ST_SCAN) && !abort),
        .last_word  (last_word),
        .flash_req  (FLASH_REQ),
        .word_valid (word_valid),
        .word_last  (word_last)
    );

    // Checksum accumulator fed straight from the flash data in the data cycle.
    flash_crc_engine flash_crc_engine_inst (
        .clk        (CORE_CLK),
        .rst_n      (RST_N),
        .clear      (scan_start),
        .word_valid (word_valid),
        .word       (FLASH_RDATA),
        .crc        (crc)
    );
endmodule

//--- verif/flash_checksum_scanner_checker.sv
// Port-level assertions for the flash checksum scanner.
`timescale 1ns/1ps
module flash_checksum_scanner_checker
    import crc_scan_pkg::*;
(
    // Watched ports.
    input  wire logic                CORE_CLK,
    input  wire logic                RST_N,
    input  crc_scan_pkg::avm_req_t   AVS_REQ,
    input  wire logic                AVS_WAITREQUEST,
    input  crc_scan_pkg::flash_req_t FLASH_REQ,
    input  wire logic                CPU_STALL,
    input  wire logic                NMI_REQ
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic go;

    // A start request accepted while idle; a strobe in the same byte would abort it.
    assign go = AVS_REQ.write && !AVS_WAITREQUEST && AVS_REQ.address == 4'h0
        && AVS_REQ.byteenable[0] && AVS_REQ.writedata[0] && !AVS_REQ.writedata[7]
        && !CPU_STALL && !NMI_REQ;

    a_nmi_sticky: assert property (NMI_REQ |=> NMI_REQ)
        else $error("interrupt request dropped");
    a_fetch_pace: assert property (FLASH_REQ.rd |=> !FLASH_REQ.rd [*2])
        else $error("fetches closer than three cycles");
    a_fetch_stall: assert property (FLASH_REQ.rd |-> CPU_STALL)
        else $error("fetch without processor halt");
    a_start_delay: assert property (go |=> !CPU_STALL [*2] ##[1:2] CPU_STALL)
        else $error("scan start not three cycles after enable");
    a_fetch_addr: assert property (FLASH_REQ.rd && $past(FLASH_REQ.rd, 3)
        |-> FLASH_REQ.addr == $past(FLASH_REQ.addr, 3) + 15'h1)
        else $error("fetch address not ascending");
    a_first_word: assert property ($rose(CPU_STALL)
        |-> ##[0:2] (FLASH_REQ.rd && FLASH_REQ.addr == 15'h0))
        else $error("scan does not begin at word zero");
    a_wait_first: assert property ($rose(AVS_REQ.read || AVS_REQ.write) |-> AVS_WAITREQUEST)
        else $error("no wait cycle on access");
    a_wait_one: assert property ((AVS_REQ.read || AVS_REQ.write) && AVS_WAITREQUEST
        |=> !AVS_WAITREQUEST)
        else $error("wait longer than one cycle");
    c_nmi: cover property ($rose(NMI_REQ));
    c_fetch: cover property (FLASH_REQ.rd);
    c_done: cover property ($fell(CPU_STALL));
endmodule

bind flash_checksum_scanner flash_checksum_scanner_checker flash_checksum_scanner_checker_inst (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_REQ(AVS_REQ),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .FLASH_REQ(FLASH_REQ),
    .CPU_STALL(CPU_STALL), .NMI_REQ(NMI_REQ));

//--- verif/flash_model.sv
// Behavioural flash array with a pattern and a checksum at each section end.
`timescale 1ns/1ps
module flash_model
    import crc_scan_pkg::*;
(
    // Clock and fetch.
    input  wire logic                clk,
    input  crc_scan_pkg::flash_req_t req,
    // Content control.
    input  wire logic [15:0]         seed,
    input  wire logic [7:0]          boot_end,
    input  wire logic [7:0]          app_end,
    input  wire logic                corrupt,
    // Read data.
    output logic [15:0]              rdata
);
    logic [15:0] mem [256];
    logic [15:0] c;

    // Folds one byte, most significant bit first.
    function automatic logic [15:0] step(input logic [15:0] s, input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            s = {s[14:0], 1'b0} ^ ((s[15] ^ b[i]) ? 16'h1021 : 16'h0000);
        return s;
    endfunction

    // Each section end holds the checksum of all bytes before it; corruption comes last.
    always @(seed or boot_end or app_end or corrupt)
    begin
        c = 16'hffff;
        for (int w = 0; w < 256; w++)
        begin
            mem[w] = seed ^ 16'(w * 257);
            if (w == boot_end * 128 - 1 || w == app_end * 128 - 1)
                mem[w] = {c[7:0], c[15:8]};
            c = step(step(c, mem[w][7:0]), mem[w][15:8]);
        end
        mem[3] = mem[3] ^ {15'h0, corrupt};
    end

    // Data follow a fetch by one cycle; otherwise the bus toggles so stale data never match.
    always @(posedge clk)
        rdata <= req.rd ? mem[req.addr[7:0]] : ~rdata;
endmodule

//--- verif/flash_crc_scan_control_tb.sv
// Self-checking bench for the flash checksum scanner.
`timescale 1ns/1ps
module flash_crc_scan_control_tb;
    import crc_scan_pkg::*;
    logic        clk = 0;
    logic        rst_n = 0;
    logic        su = 1;
    logic        bad = 0;
    avm_req_t    req = '0;
    flash_req_t  freq;
    logic [31:0] rdata;
    logic [15:0] fdata;
    logic [15:0] seed;
    logic [15:0] e;
    logic [15:0] q[$];
    logic        wreq, stall, ok, nmi;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;

    flash_checksum_scanner flash_checksum_scanner_inst (.CORE_CLK(clk), .RST_N(rst_n),
        .AVS_REQ(req), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
        .STARTUP_SCAN_EN(su), .STARTUP_SRC(2'h2), .FUSE_BOOTEND(8'h01),
        .FUSE_APPEND(8'h02), .FLASH_REQ(freq), .FLASH_RDATA(fdata),
        .CPU_STALL(stall), .CPU_RUN_OK(ok), .NMI_REQ(nmi));
    flash_model flash_model_inst (.clk(clk), .req(freq), .seed(seed),
        .boot_end(8'h01), .app_end(8'h02), .corrupt(bad), .rdata(fdata));

    // Free-running core clock.
    initial
        forever #5 clk = ~clk;

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // A hang counts as a mismatch.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    // One access; the request holds until the edge that sees waitrequest low.
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
        input logic [7:0] m = 8'hff);
        if (!w)
            q.push_back({d, m});
        req <= {!w, w, a, 24'h0, d, 4'h1};
        do
            @(posedge clk);
        while (wreq !== 1'b0);
        req <= '0;
        @(posedge clk);
    endtask

    // Each read answer meets the oldest note, masked where bits are not valid.
    always @(posedge clk)
    begin
        if (req.read && wreq === 1'b0)
        begin
            e = q.pop_front();
            chk(rdata[7:0] & e[7:0], e[15:8] & e[7:0]);
        end
    end

    task automatic rst(input logic s);
        rst_n <= 1'b0;
        su <= s;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    // Waits for the halt to fall; only the bench timeout ends a hung scan.
    task automatic scan_wait();
        repeat (8) @(posedge clk);
        while (stall !== 1'b0)
            @(posedge clk);
        repeat (2) @(posedge clk);
    endtask

    initial
    begin
        void'($urandom(43));
        seed <= 16'($urandom);
        rst(1'b1);
        scan_wait();
        chk({7'h0, ok}, 8'h01);
        acc(0, 4'h0, 8'h01);
        acc(0, 4'h4, 8'h12);
        acc(0, 4'h8, 8'h02);
        acc(1, 4'h4, 8'h02);
        rst(1'b0);
        acc(0, 4'h0, 8'h00);
        acc(0, 4'h4, 8'h00);
        acc(0, 4'h8, 8'h02);
        acc(0, 4'hc, 8'h00);
        for (int s = 1; s < 3; s++)
        begin
            seed <= 16'($urandom);
            acc(1, 4'h4, 8'(s));
            acc(1, 4'h0, 8'h01);
            acc(0, 4'h8, 8'h01, 8'h01);
            acc(1, 4'h4, 8'h00);
            acc(1, 4'h0, 8'h02);
            scan_wait();
            acc(0, 4'h4, 8'(s));
            acc(0, 4'h0, 8'h01);
            acc(0, 4'h8, 8'h02);
        end
        bad <= 1'b1;
        acc(1, 4'h0, 8'h01);
        scan_wait();
        acc(0, 4'h8, 8'h00);
        chk({7'h0, nmi}, 8'h00);
        acc(1, 4'h8, 8'h02);
        acc(0, 4'h8, 8'h02);
        acc(1, 4'h0, 8'h01);
        repeat (6) @(posedge clk);
        acc(1, 4'h0, 8'h80);
        acc(0, 4'h0, 8'h00);
        acc(0, 4'h4, 8'h00);
        acc(0, 4'h8, 8'h00);
        acc(1, 4'h8, 8'h01);
        acc(0, 4'h8, 8'h01, 8'h01);
        acc(1, 4'h8, 8'h00);
        acc(0, 4'h8, 8'h00);
        acc(1, 4'h4, 8'h02);
        acc(1, 4'h0, 8'h02);
        acc(0, 4'h0, 8'h02);
        acc(1, 4'h0, 8'h01);
        acc(1, 4'h0, 8'h80);
        scan_wait();
        chk({7'h0, nmi}, 8'h01);
        acc(0, 4'h8, 8'h00);
        acc(1, 4'h0, 8'h80);
        acc(0, 4'h0, 8'h03);
        rst(1'b0);
        acc(1, 4'h0, 8'h02);
        acc(1, 4'h8, 8'h00);
        chk({7'h0, nmi}, 8'h01);
        finish_test();
    end
endmodule
